//--- logic/dec_defines.svh
`ifndef DEC_DEFINES_SVH
`define DEC_DEFINES_SVH

// Opcode fields of the first word; NIB_SECOND and BYTE_PTR_SECOND are second-word fields.
`define NIB_BIT_CLEAR 4'h9
`define NIB_BIT_SET 4'h8
`define NIB_BIT_TOGGLE 4'h7
`define NIB_SKIP_CLEAR 4'hb
`define NIB_SKIP_SET 4'ha
`define NIB_SECOND 4'hf
`define NIB_MOVE_PAIR 4'hc
`define HI5_BRANCH 5'h1c
`define HI7_CALL 7'h76
`define BYTE_GOTO 8'hef
`define BYTE_PTR_LOAD 8'hee
`define BYTE_PTR_SECOND 8'hf0
`define BITS_PTR_ZERO 2'h0
`define BYTE_ADD_LIT 8'h0f
`define BYTE_SUB_LIT 8'h08
`define BYTE_AND_LIT 8'h0b
`define BYTE_OR_LIT 8'h09
`define BYTE_XOR_LIT 8'h0a
`define BYTE_MOVE_LIT 8'h0e
`define BYTE_MUL_LIT 8'h0d
`define BYTE_RET_LIT 8'h0c
`define HI12_BANK_LOAD 12'h010
`define WORD_SLEEP 16'h0003
`define WORD_WDT_CLEAR 16'h0004
`define WORD_PUSH 16'h0005
`define WORD_POP 16'h0006
`define HI15_INT_RETURN 15'h0008
`define HI15_RETURN 15'h0009
`define HI14_TABLE_READ 14'h0002
`define HI14_TABLE_WRITE 14'h0003

// Branch condition pairs; the low condition bit inverts the test.
`define COND_ZERO 2'h0
`define COND_CARRY 2'h1
`define COND_OVERFLOW 2'h2

// Status flag positions and masks of flags an instruction updates.
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_N 4
`define MASK_NONE 5'h00
`define MASK_ARITH 5'h1f
`define MASK_LOGIC 5'h14

// Bit operation codes.
`define BITOP_CLEAR 2'h0
`define BITOP_SET 2'h1
`define BITOP_TOGGLE 2'h2

// Special file addresses and access bank halves.
`define ADDR_TIMER_ZERO 12'hf90
`define ADDR_PORT_B 12'hf80
`define BANK_ACCESS_LO 4'h0
`define BANK_ACCESS_HI 4'hf

// APB register map.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COUNT 12'h008
`define CTRL_EN_BIT 0
`define CTRL_PRESC_BIT 1
`define CTRL_EN_RESET 1'b1

`endif

//--- logic/dec_pkg.sv
`default_nettype none

package dec_pkg;

  typedef enum logic [2:0] {
    ST_FETCH, ST_SECOND, ST_FLUSH, ST_SKIP, ST_SKIP_SECOND
  } decState_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_BIT, OP_SKIP, OP_BRANCH, OP_CALL, OP_GOTO, OP_RETURN, OP_INT_RETURN,
    OP_RET_LIT, OP_STACK, OP_SYS, OP_LITERAL, OP_BANK, OP_POINTER, OP_TABLE, OP_OTHER
  } opClass_t;

  typedef struct packed {
    decState_t state;
    logic [15:0] firstWord;
    logic [3:0] bank_select_register;
    logic ctrlEn;
    logic ctrlPresc;
    logic [15:0] retired;
    opClass_t opClass;
    logic opStrobe;
    logic [11:0] fileAddr;
    logic [2:0] bitIndex;
    logic [1:0] bitOp;
    logic [7:0] literal;
    logic [19:0] pcTarget;
    logic pcLoad;
    logic pcFromStack;
    logic fastSave;
    logic [4:0] flagMask;
    logic toPdUpdate;
    logic stackPush;
    logic stackPop;
    logic wdtClear;
    logic sleepEnter;
    logic intEnHigh;
    logic intEnLow;
    logic [1:0] pointerSel;
    logic [11:0] pointerValue;
    logic pointerLoad;
    logic [1:0] tableMode;
    logic tableWrite;
    logic tableGo;
    logic usePins;
    logic prescClear;
    logic [31:0] prdata;
    logic pslverr;
  } decoder_t;

endpackage

`default_nettype wire

//--- logic/cpu_instruction_decoder.sv
// Contract
// - Nibbles 9,8,7 decode bit clear/set/toggle.
// - Nibbles b,a skip-if-clear/set, extra skip cycles.
// - Branch zero/nonzero/carry/no-carry, two cycles taken.
// - Branch overflow/negative variants change no flags.
// - Call is two words with fast save.
// - Absolute jump two words, 20-bit target.
// - Lone second-word pattern executes as no-op.
// - PC change costs second no-op cycle.
// - Push and pop: one cycle, no flags.
// - Interrupt return re-enables enable by priority.
// - Return and return-with-literal: two cycles, no flags.
// - Standby and watchdog clear update timeout/powerdown bits.
// - Literal add/subtract update all five flags.
// - Literal and/or/xor update zero, negative only.
// - Literal move and multiply affect no flags.
// - Bank load writes bank select low nibble.
// - Pointer load: two words, 12-bit value.
// - Table read with four pointer update modes.
// - Table write with same update modes.
// - Port read-modify-write uses pin values.
// - Timer-zero write clears assigned prescaler.
// - Access bank when bit zero, else bank select.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dec_defines.svh"

module cpu_instruction_decoder (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] instrWord,
  input wire logic wordValid,
  output logic wordReady,
  input wire logic [19:0] pcNext,
  input wire logic [4:0] statusFlags,
  input wire logic bitTestValue,
  input wire logic inHighIsr,
  output logic opStrobe,
  output dec_pkg::opClass_t opClass,
  output logic [11:0] fileAddr,
  output logic [2:0] bitIndex,
  output logic [1:0] bitOp,
  output logic [7:0] literal,
  output logic [19:0] pcTarget,
  output logic pcLoad,
  output logic pcFromStack,
  output logic fastSave,
  output logic [4:0] flagMask,
  output logic toPdUpdate,
  output logic stackPush,
  output logic stackPop,
  output logic wdtClear,
  output logic sleepEnter,
  output logic intEnHigh,
  output logic intEnLow,
  output logic [3:0] bankSelect,
  output logic [1:0] pointerSel,
  output logic [11:0] pointerValue,
  output logic pointerLoad,
  output logic [1:0] tableMode,
  output logic tableWrite,
  output logic tableGo,
  output logic usePins,
  output logic prescClear,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import dec_pkg::*;

  decoder_t s;
  decoder_t n;
  logic take;
  logic condTrue;
  logic [11:0] effAddr;

  // Words are only accepted while software has the decoder enabled.
  assign take = wordValid && s.ctrlEn;
  assign wordReady = s.ctrlEn;
  assign pready = 1'b1;

  assign effAddr = instrWord[8] ? {s.bank_select_register, instrWord[7:0]} :
                   {(instrWord[7] ? `BANK_ACCESS_HI : `BANK_ACCESS_LO), instrWord[7:0]};

  // condition select; the low code bit inverts the tested flag.
  always_comb begin
    case (instrWord[10:9])
      `COND_ZERO: condTrue = statusFlags[`FLG_Z] ^ instrWord[8];
      `COND_CARRY: condTrue = statusFlags[`FLG_C] ^ instrWord[8];
      `COND_OVERFLOW: condTrue = statusFlags[`FLG_OV] ^ instrWord[8];
      default: condTrue = statusFlags[`FLG_N] ^ instrWord[8];
    endcase
  end

  // Next-state logic: decode, two-word tracking, flush and skip, APB access.
  always_comb begin
    n = s;
    n.opStrobe = 1'b0;
    n.pcLoad = 1'b0;
    n.pcFromStack = 1'b0;
    n.stackPush = 1'b0;
    n.stackPop = 1'b0;
    n.wdtClear = 1'b0;
    n.sleepEnter = 1'b0;
    n.intEnHigh = 1'b0;
    n.intEnLow = 1'b0;
    n.pointerLoad = 1'b0;
    n.tableGo = 1'b0;
    n.prescClear = 1'b0;
    n.usePins = 1'b0;
    n.toPdUpdate = 1'b0;
    n.flagMask = `MASK_NONE;
    if (take) begin
      n.opStrobe = 1'b1;
      n.opClass = OP_NOP;
      case (s.state)
        ST_FETCH: begin
          n.retired = s.retired + 16'h0001;
          if (instrWord[15:12] == `NIB_BIT_CLEAR || instrWord[15:12] == `NIB_BIT_SET ||
              instrWord[15:12] == `NIB_BIT_TOGGLE) begin
            n.opClass = OP_BIT;
            n.bitIndex = instrWord[11:9];
            n.fileAddr = effAddr;
            n.bitOp = (instrWord[15:12] == `NIB_BIT_CLEAR) ? `BITOP_CLEAR :
                      (instrWord[15:12] == `NIB_BIT_SET) ? `BITOP_SET : `BITOP_TOGGLE;
            n.usePins = (effAddr == `ADDR_PORT_B);
            n.prescClear = (effAddr == `ADDR_TIMER_ZERO) && s.ctrlPresc;
          end else if (instrWord[15:12] == `NIB_SKIP_CLEAR ||
                       instrWord[15:12] == `NIB_SKIP_SET) begin
            n.opClass = OP_SKIP;
            n.bitIndex = instrWord[11:9];
            n.fileAddr = effAddr;
            if (bitTestValue == (instrWord[15:12] == `NIB_SKIP_SET)) begin
              n.state = ST_SKIP;
            end
          end else if (instrWord[15:11] == `HI5_BRANCH) begin
            n.opClass = OP_BRANCH;
            n.pcTarget = pcNext + {{12{instrWord[7]}}, instrWord[7:0]};
            if (condTrue) begin
              n.pcLoad = 1'b1;
              n.state = ST_FLUSH;
            end
          end else if (instrWord[15:9] == `HI7_CALL || instrWord[15:8] == `BYTE_GOTO ||
                       (instrWord[15:8] == `BYTE_PTR_LOAD &&
                        instrWord[7:6] == `BITS_PTR_ZERO) ||
                       instrWord[15:12] == `NIB_MOVE_PAIR) begin
            n.firstWord = instrWord;
            n.state = ST_SECOND;
            n.opStrobe = 1'b0;
          end else if (instrWord[15:12] == `NIB_SECOND) begin
            n.opClass = OP_NOP;
          end else if (instrWord == `WORD_PUSH || instrWord == `WORD_POP) begin
            n.opClass = OP_STACK;
            n.stackPush = (instrWord == `WORD_PUSH);
            n.stackPop = (instrWord == `WORD_POP);
          end else if (instrWord == `WORD_SLEEP || instrWord == `WORD_WDT_CLEAR) begin
            n.opClass = OP_SYS;
            n.sleepEnter = (instrWord == `WORD_SLEEP);
            n.wdtClear = (instrWord == `WORD_WDT_CLEAR);
            n.toPdUpdate = 1'b1;
          end else if (instrWord[15:1] == `HI15_INT_RETURN) begin
            n.opClass = OP_INT_RETURN;
            n.fastSave = instrWord[0];
            n.pcFromStack = 1'b1;
            n.intEnHigh = inHighIsr;
            n.intEnLow = !inHighIsr;
            n.state = ST_FLUSH;
          end else if (instrWord[15:1] == `HI15_RETURN ||
                       instrWord[15:8] == `BYTE_RET_LIT) begin
            n.opClass = (instrWord[15:8] == `BYTE_RET_LIT) ? OP_RET_LIT : OP_RETURN;
            n.fastSave = (instrWord[15:8] != `BYTE_RET_LIT) && instrWord[0];
            n.literal = instrWord[7:0];
            n.pcFromStack = 1'b1;
            n.state = ST_FLUSH;
          end else if (instrWord[15:8] == `BYTE_ADD_LIT ||
                       instrWord[15:8] == `BYTE_SUB_LIT) begin
            n.opClass = OP_LITERAL;
            n.literal = instrWord[7:0];
            n.flagMask = `MASK_ARITH;
          end else if (instrWord[15:8] == `BYTE_AND_LIT || instrWord[15:8] == `BYTE_OR_LIT ||
                       instrWord[15:8] == `BYTE_XOR_LIT) begin
            n.opClass = OP_LITERAL;
            n.literal = instrWord[7:0];
            n.flagMask = `MASK_LOGIC;
          end else if (instrWord[15:8] == `BYTE_MOVE_LIT ||
                       instrWord[15:8] == `BYTE_MUL_LIT) begin
            n.opClass = OP_LITERAL;
            n.literal = instrWord[7:0];
          end else if (instrWord[15:4] == `HI12_BANK_LOAD) begin
            n.opClass = OP_BANK;
            n.bank_select_register = instrWord[3:0];
          end else if (instrWord[15:2] == `HI14_TABLE_READ ||
                       instrWord[15:2] == `HI14_TABLE_WRITE) begin
            n.opClass = OP_TABLE;
            n.tableMode = instrWord[1:0];
            n.tableWrite = (instrWord[15:2] == `HI14_TABLE_WRITE);
            n.tableGo = 1'b1;
            n.state = ST_FLUSH;
          end else begin
            n.opClass = OP_OTHER;
          end
        end
        ST_SECOND: begin
          n.state = ST_FETCH;
          if (s.firstWord[15:9] == `HI7_CALL || s.firstWord[15:8] == `BYTE_GOTO) begin
            n.opClass = (s.firstWord[15:8] == `BYTE_GOTO) ? OP_GOTO : OP_CALL;
            n.pcTarget = {instrWord[11:0], s.firstWord[7:0]};
            n.pcLoad = 1'b1;
            n.stackPush = (s.firstWord[15:8] != `BYTE_GOTO);
            n.fastSave = (s.firstWord[15:8] != `BYTE_GOTO) && s.firstWord[8];
          end else if (s.firstWord[15:8] == `BYTE_PTR_LOAD) begin
            n.opClass = OP_POINTER;
            n.pointerSel = s.firstWord[5:4];
            n.pointerValue = {s.firstWord[3:0], instrWord[7:0]};
            n.pointerLoad = 1'b1;
          end else begin
            n.opClass = OP_OTHER;
          end
        end
        ST_SKIP: begin
          // skipped two-word costs a third cycle
          if (instrWord[15:9] == `HI7_CALL || instrWord[15:8] == `BYTE_GOTO ||
              (instrWord[15:8] == `BYTE_PTR_LOAD && instrWord[7:6] == `BITS_PTR_ZERO) ||
              instrWord[15:12] == `NIB_MOVE_PAIR) begin
            n.state = ST_SKIP_SECOND;
          end else begin
            n.state = ST_FETCH;
          end
        end
        ST_FLUSH: n.state = ST_FETCH;
        ST_SKIP_SECOND: n.state = ST_FETCH;
        default: n.state = ST_FETCH;
      endcase
    end
    // APB: read data is built in the setup cycle so it stands registered in the access.
    if (psel && !penable) begin
      n.pslverr = !(paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_COUNT);
      case (paddr)
        `REG_CTRL: n.prdata = {30'h0, s.ctrlPresc, s.ctrlEn};
        `REG_STATUS: n.prdata = {21'h0, s.bank_select_register, s.opClass, s.state};
        `REG_COUNT: n.prdata = {16'h0, s.retired};
        default: n.prdata = 32'h0;
      endcase
    end
    if (psel && penable && pwrite && paddr == `REG_CTRL) begin
      n.ctrlEn = pwdata[`CTRL_EN_BIT];
      n.ctrlPresc = pwdata[`CTRL_PRESC_BIT];
    end
  end

  // State register; decode outputs all come from here.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.ctrlEn <= `CTRL_EN_RESET;
    end else begin
      s <= n;
    end
  end

  // Output wiring.
  assign opStrobe = s.opStrobe;
  assign opClass = s.opClass;
  assign fileAddr = s.fileAddr;
  assign bitIndex = s.bitIndex;
  assign bitOp = s.bitOp;
  assign literal = s.literal;
  assign pcTarget = s.pcTarget;
  assign pcLoad = s.pcLoad;
  assign pcFromStack = s.pcFromStack;
  assign fastSave = s.fastSave;
  assign flagMask = s.flagMask;
  assign toPdUpdate = s.toPdUpdate;
  assign stackPush = s.stackPush;
  assign stackPop = s.stackPop;
  assign wdtClear = s.wdtClear;
  assign sleepEnter = s.sleepEnter;
  assign intEnHigh = s.intEnHigh;
  assign intEnLow = s.intEnLow;
  assign bankSelect = s.bank_select_register;
  assign pointerSel = s.pointerSel;
  assign pointerValue = s.pointerValue;
  assign pointerLoad = s.pointerLoad;
  assign tableMode = s.tableMode;
  assign tableWrite = s.tableWrite;
  assign tableGo = s.tableGo;
  assign usePins = s.usePins;
  assign prescClear = s.prescClear;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  // Checks on decoded outputs.
  property p_bit_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:12] == `NIB_BIT_CLEAR |=>
      opClass == OP_BIT && bitOp == `BITOP_CLEAR && bitIndex == $past(instrWord[11:9]);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear misdecoded");

  property p_skip_taken;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:12] == `NIB_SKIP_SET && bitTestValue |=>
      s.state == ST_SKIP ##1 (take ? !opStrobe || opClass == OP_NOP : 1'b1);
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skip not taken");

  property p_branch_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:8] == 8'he0 && statusFlags[`FLG_Z] |=>
      pcLoad && flagMask == `MASK_NONE &&
      pcTarget == $past(pcNext + {{12{instrWord[7]}}, instrWord[7:0]});
  endproperty
  a_branch_zero: assert property (p_branch_zero) else $error("branch target wrong");

  property p_branch_flush;
    @(posedge clk_sys) disable iff (!rst_b)
    pcLoad && opClass == OP_BRANCH |-> s.state == ST_FLUSH;
  endproperty
  a_branch_flush: assert property (p_branch_flush) else $error("no flush cycle");

  property p_goto_two;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:8] == `BYTE_GOTO |=>
      s.state == ST_SECOND && !pcLoad;
  endproperty
  a_goto_two: assert property (p_goto_two) else $error("jump not two words");

  property p_lone_second;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:12] == `NIB_SECOND |=>
      opClass == OP_NOP && !pcLoad;
  endproperty
  a_lone_second: assert property (p_lone_second) else $error("lone word not no-op");

  property p_push;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord == `WORD_PUSH |=>
      stackPush && flagMask == `MASK_NONE ##1
      stackPush == $past(take && s.state == ST_FETCH && instrWord == `WORD_PUSH);
  endproperty
  a_push: assert property (p_push) else $error("push misdecoded");

  property p_bank_load;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:4] == `HI12_BANK_LOAD |=>
      bankSelect == $past(instrWord[3:0]);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank not loaded");

  property p_add_flags;
    @(posedge clk_sys) disable iff (!rst_b)
    take && s.state == ST_FETCH && instrWord[15:8] == `BYTE_ADD_LIT |=>
      flagMask == `MASK_ARITH;
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flag mask wrong");

  property p_presc;
    @(posedge clk_sys) disable iff (!rst_b)
    prescClear |-> opClass == OP_BIT && fileAddr == `ADDR_TIMER_ZERO;
  endproperty
  a_presc: assert property (p_presc) else $error("spurious prescaler clear");

endmodule // cpu_instruction_decoder

`default_nettype wire

//--- tb/prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// Program memory stand-in: offers queued words one at a time, each until it is taken.
module prog_mem_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wordReady,
  output logic [15:0] instrWord,
  output logic wordValid
);
  logic [15:0] pending[$];

  // Callers queue words between clock edges, so the fetch process never races them.
  task automatic put(input logic [15:0] w);
    pending.push_back(w);
  endtask

  // An idle bus toggles every cycle, so a stale word can never pass for a fresh one.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wordValid <= 1'b0;
      instrWord <= 16'h5a5a;
    end else begin
      if (wordValid && wordReady) begin
        void'(pending.pop_front());
      end
      if (pending.size() != 0) begin
        wordValid <= 1'b1;
        instrWord <= pending[0];
      end else begin
        wordValid <= 1'b0;
        instrWord <= ~instrWord;
      end
    end
  end
endmodule // prog_mem_model

`default_nettype wire

//--- tb/cpu_instruction_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_instruction_decoder_tb_top;
  import dec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] instrWord;
  logic wordValid, wordReady;
  logic [19:0] pcNext = 20'h00000, pcTarget, pc;
  logic [4:0] statusFlags = 5'h00, flagMask, fl;
  logic bitTestValue = 1'b0, inHighIsr = 1'b0, bt, hi;
  opClass_t opClass;
  logic [11:0] fileAddr, pointerValue, paddr = 12'h000;
  logic [7:0] literal;
  logic [3:0] bankSelect, bank_select_register;
  logic [2:0] bitIndex;
  logic [1:0] bitOp, pointerSel, tableMode;
  logic opStrobe, pcLoad, pcFromStack, fastSave, toPdUpdate, stackPush, stackPop, wdtClear;
  logic sleepEnter, intEnHigh, intEnLow, pointerLoad, tableWrite, tableGo, usePins, prescClear;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int nErrors = 0, nCompared = 0;
  logic [15:0] sysW [9] = '{16'h0005, 16'h0006, 16'h0003, 16'h0004, 16'h0010, 16'h0011,
    16'h0012, 16'h0013, 16'h0c5a};
  opClass_t sysC [9] = '{OP_STACK, OP_STACK, OP_SYS, OP_SYS, OP_INT_RETURN, OP_INT_RETURN,
    OP_RETURN, OP_RETURN, OP_RET_LIT};
  logic [10:0] sysP [9] = '{11'h100, 11'h080, 11'h050, 11'h060, 11'h200, 11'h200, 11'h200,
    11'h200, 11'h200};
  logic [7:0] litOp [7] = '{8'h0f, 8'h08, 8'h0b, 8'h09, 8'h0a, 8'h0e, 8'h0d};
  logic [4:0] litMask [7] = '{5'h1f, 5'h1f, 5'h14, 5'h14, 5'h14, 5'h00, 5'h00};
  wire logic [10:0] pulses = {pcLoad, pcFromStack, stackPush, stackPop, toPdUpdate, wdtClear,
    sleepEnter, intEnHigh, intEnLow, tableGo, pointerLoad};

  cpu_instruction_decoder u_cpu_instruction_decoder (.clk_sys, .rst_b, .instrWord, .wordValid,
    .wordReady, .pcNext, .statusFlags, .bitTestValue, .inHighIsr, .opStrobe, .opClass,
    .fileAddr, .bitIndex, .bitOp, .literal, .pcTarget, .pcLoad, .pcFromStack, .fastSave,
    .flagMask, .toPdUpdate, .stackPush, .stackPop, .wdtClear, .sleepEnter, .intEnHigh,
    .intEnLow, .bankSelect, .pointerSel, .pointerValue, .pointerLoad, .tableMode, .tableWrite,
    .tableGo, .usePins, .prescClear, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  prog_mem_model u_prog_mem_model (.clk_sys, .rst_b, .wordReady, .instrWord, .wordValid);

  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  // Access bank splits on the top address bit; otherwise the bank register picks the bank.
  function automatic logic [11:0] effAddr(input logic a, input logic [7:0] f);
    return a ? {bank_select_register, f} : {f[7] ? 4'hf : 4'h0, f};
  endfunction

  // Condition pairs share a flag; the low condition bit inverts the test.
  function automatic logic taken(input logic [2:0] c, input logic [4:0] s);
    logic v;
    case (c[2:1])
      2'h0: v = s[2];
      2'h1: v = s[0];
      2'h2: v = s[3];
      default: v = s[4];
    endcase
    return v ^ c[0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t decode got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkBus(input logic e, input logic [31:0] d);
    nCompared++;
    if ({er, rd} !== {e, d}) begin
      nErrors++;
      $display("MISMATCH t=%0t bus got %b %h exp %b %h", $time, er, rd, e, d);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Queues up to three words; returns at the settled point after the first is decoded.
  task automatic feed(input logic [15:0] a, b, c, input int n);
    @(negedge clk_sys);
    u_prog_mem_model.put(a);
    if (n > 1) u_prog_mem_model.put(b);
    if (n > 2) u_prog_mem_model.put(c);
    pc = 20'($urandom);
    @(posedge clk_sys);
    pcNext <= pc;
    statusFlags <= fl;
    bitTestValue <= bt;
    inHighIsr <= hi;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, registers, then every instruction group with corner cases.
  initial begin
    logic [15:0] w;
    logic [7:0] k;
    logic [11:0] h;
    logic [10:0] p, care;
    logic t;
    opClass_t oc;
    void'($urandom(32'h0141f806));
    fl = 5'h00;
    bt = 1'b0;
    hi = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk({wordReady, pready, opStrobe, pulses}, {3'b110, 11'h000});
    apb(1'b0, 12'h000, 32'h0);
    chkBus(1'b0, 32'h1);
    apb(1'b1, 12'h00c, 32'h0);
    chkBus(1'b1, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chkBus(1'b0, 32'h1);
    bank_select_register = 4'($urandom);
    feed({12'h010, bank_select_register}, 16'h0, 16'h0, 1);
    chk({opStrobe, opClass, bankSelect, flagMask}, {1'b1, OP_BANK, bank_select_register, 5'h00});
    apb(1'b0, 12'h008, 32'h0);
    chkBus(1'b0, 32'h1);
    for (int i = 0; i < 12; i++) begin
      if (i % 3 == 0) apb(1'b1, 12'h000, {30'h0, i < 3, 1'b1});
      w = {i % 3 == 0 ? 4'h9 : i % 3 == 1 ? 4'h8 : 4'h7, 12'($urandom)};
      if (i < 6) w[8:0] = i[0] ? 9'h090 : 9'h080;
      feed(w, 16'h0, 16'h0, 1);
      h = effAddr(w[8], w[7:0]);
      chk({opClass, fileAddr, bitIndex, bitOp, flagMask},
          {OP_BIT, h, w[11:9], 2'(i % 3), 5'h00});
      chk({usePins, prescClear}, {h == 12'hf80, h == 12'hf90 && i < 3});
    end
    for (int i = 0; i < 7; i++) begin
      k = 8'($urandom);
      feed({litOp[i], k}, 16'h0, 16'h0, 1);
      chk({opStrobe, opClass, literal, flagMask, pulses},
          {1'b1, OP_LITERAL, k, litMask[i], 11'h0});
    end
    for (int i = 0; i < 16; i++) begin
      k = 8'($urandom);
      fl = 5'($urandom);
      feed({5'h1c, 3'(i), k}, {8'h0e, ~k}, 16'h0, 2);
      t = taken(3'(i), fl);
      chk({opClass, pcLoad, flagMask}, {OP_BRANCH, t, 5'h00});
      if (t) chk(pcTarget, 20'(pc + {{12{k[7]}}, k}));
      @(negedge clk_sys);
      chk(t ? {opClass, pulses} : {opClass, literal},
          t ? {OP_NOP, 11'h000} : {OP_LITERAL, ~k});
    end
    for (int i = 0; i < 4; i++) begin
      k = 8'($urandom);
      h = 12'($urandom);
      feed(i < 2 ? {8'hef, k} : {7'h76, i[0], k}, {4'hf, h}, 16'h0, 2);
      chk(opStrobe, 1'b0);
      @(negedge clk_sys);
      chk({opClass, pulses},
          {i < 2 ? OP_GOTO : OP_CALL, 2'b10, i > 1, 8'h00});
      chk(pcTarget, {h, k});
      if (i > 1) chk(fastSave, i[0]);
    end
    k = 8'($urandom);
    h = 12'($urandom);
    feed({10'h3b8, h[5:0]}, {8'hf0, k}, 16'h0, 2);
    @(negedge clk_sys);
    chk({opClass, pointerSel, pointerValue, pulses},
        {OP_POINTER, h[5:4], h[3:0], k, 11'h001});
    feed({4'hf, h}, 16'h0, 16'h0, 1);
    chk({opClass, pulses}, {OP_NOP, 11'h000});
    for (int i = 0; i < 4; i++) begin
      bt = i[1];
      t = i[0] ? !bt : bt;
      feed({i[0] ? 4'hb : 4'ha, 12'($urandom)}, {8'hef, 8'($urandom)}, 16'hf000, 3);
      chk(opClass, OP_SKIP);
      repeat (2) @(negedge clk_sys);
      chk(pcLoad, !t);
    end
    for (int i = 0; i < 17; i++) begin
      hi = 1'($urandom);
      k = 8'($urandom);
      w = i < 9 ? sysW[i] : 16'h0008 + 16'(i - 9);
      oc = i < 9 ? sysC[i] : OP_TABLE;
      p = i < 9 ? sysP[i] : 11'h002;
      if (i == 4 || i == 5) p = p | (hi ? 11'h008 : 11'h004);
      care = i > 3 && i < 9 ? 11'h37f : 11'h7ff;
      feed(w, {8'h0e, k}, 16'h0, 2);
      chk({opClass, flagMask, pulses & care},
          {oc, 5'h00, p});
      if (i > 3 && i < 8) chk(fastSave, w[0]);
      if (i == 8) chk(literal, 8'h5a);
      if (i > 8) chk({tableMode, tableWrite}, {w[1:0], w[2]});
      @(negedge clk_sys);
      chk(opClass, i > 3 ? OP_NOP : OP_LITERAL);
    end
    apb(1'b1, 12'h000, 32'h0);
    k = 8'($urandom);
    feed({8'h0e, k}, 16'h0, 16'h0, 1);
    chk({wordReady, opStrobe}, 2'b00);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({opClass, literal}, {OP_LITERAL, k});
    apb(1'b0, 12'h004, 32'h0);
    chkBus(1'b0, {21'h0, bank_select_register, OP_LITERAL, ST_FETCH});
    summarize();
  end

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    nErrors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
endmodule // cpu_instruction_decoder_tb_top

`default_nettype wire
